/* chgi2c_pkg.sv */
// How it works
// - Slave only; one protocol serves both the 100 kbps and 400 kbps rates.
// - Only 7-bit addressing; answers the fixed address 0x6A (byte 0xD4).
// - Data line low past stuck_bus_timeout resets the engine; transaction ignored.
// - Stuck-bus timer restarts on START and repeated START, stops at STOP.
// - START is data falling while clock high; the port recognises it.
// - Only on address match, data held low through the ninth clock high.
// - Direction bit 0 means host writes; 1 means port sends bytes.
// - Units are eight data bits plus an acknowledge from the receiver.
// - STOP is data rising while clock high; port then releases the link.
// - After STOP the port idles until a START and a matching address.
// - Reads of unmapped register addresses return 0xFF.
package chgi2c_pkg;

  localparam int unsigned SYS_CLK_MHZ = 250;
  // Stuck-bus timeout in microseconds and its count of system clocks
  localparam int unsigned STUCK_BUS_TIMEOUT_US = 50000;
  localparam int unsigned STUCK_BUS_TIMEOUT_CYC = STUCK_BUS_TIMEOUT_US * SYS_CLK_MHZ;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W  = 4;

  localparam logic [6:0]        DEV_ADDR    = 7'h6A;
  localparam logic [7:0]        UNMAPPED_RD = 8'hFF;
  localparam logic [CNT_W-1:0]  BIT_LAST    = 4'h7;
  localparam logic [CNT_W-1:0]  BIT_ACK     = 4'h8;
  localparam logic [CNT_W-1:0]  CNT_RST     = 4'h0;
  localparam logic [7:0]        BYTE_RST    = 8'h00;

  // Direction bit position inside the address byte
  localparam int unsigned DIR_BIT = 0;

  typedef enum logic [2:0] {
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RD,
    ST_IGNORE
  } chgi2c_state_type;

endpackage

/* chgi2c_mon_if.sv */
`timescale 1ns/1ps
interface chgi2c_mon_if;
  logic start;
  logic stop;
  logic sda_low;
  logic timeout;
  logic running;

  modport ctrl (
    output start,
    output stop,
    output sda_low,
    input  timeout,
    input  running
  );

  modport timer (
    input  start,
    input  stop,
    input  sda_low,
    output timeout,
    output running
  );
endinterface // chgi2c_mon_if

/* chgi2c_sync.sv */
`timescale 1ns/1ps
module chgi2c_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // chgi2c_sync

/* chgi2c_stuck_timer.sv */
`timescale 1ns/1ps
module chgi2c_stuck_timer #(
  parameter int unsigned LIMIT = chgi2c_pkg::STUCK_BUS_TIMEOUT_CYC
) (
  input  wire logic  sys_clk_i,
  input  wire logic  rst_i,
  chgi2c_mon_if.timer mon
);
  import chgi2c_pkg::*;

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        to_r;
  wire         hit;

  assign hit     = run_r & mon.sda_low & ~mon.start & (cnt_r == LIMIT - 1);
  assign run_nxt = mon.start ? 1'b1 : ((mon.stop | hit) ? 1'b0 : run_r);
  // Count only consecutive low time inside a transaction
  assign cnt_nxt = (mon.start | ~run_r | ~mon.sda_low) ? 32'h0000_0000 : cnt_r + 32'h0000_0001;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0000_0000;
      run_r <= 1'b0;
      to_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      to_r  <= hit;
    end
  end

  assign mon.timeout = to_r;
  assign mon.running = run_r;
endmodule // chgi2c_stuck_timer

/* chgi2c_top.sv */
`timescale 1ns/1ps
module chgi2c_top #(
  parameter int unsigned STUCK_CYCLES = chgi2c_pkg::STUCK_BUS_TIMEOUT_CYC
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          scl_clk_i,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe_o,
  output logic [chgi2c_pkg::BYTE_W-1:0]      reg_addr_o,
  output logic [chgi2c_pkg::BYTE_W-1:0]      reg_wdata_o,
  output logic                               reg_wr_o,
  output logic                               reg_rd_o,
  input  wire logic [chgi2c_pkg::BYTE_W-1:0] reg_rdata_i,
  input  wire logic                          reg_valid_i,
  output logic                               busy_o,
  output logic                               timeout_o
);
  import chgi2c_pkg::*;

  // ---------------------------------------------------------------
  // System domain declarations
  // ---------------------------------------------------------------
  logic [1:0]        pin_s;
  logic [2:0]        tgl_s;
  logic [2:0]        tgl_d_r;
  logic              sda_d_r;
  logic              link_rst_r;
  logic              link_rst_nxt;
  logic [7:0]        reg_addr_r;
  logic [7:0]        reg_wdata_r;
  logic              reg_wr_r;
  logic              reg_rd_r;
  logic [1:0]        fetch_q_r;
  logic [7:0]        rd_byte_r;
  logic [7:0]        rd_byte_nxt;
  logic              timeout_r;

  wire               scl_s;
  wire               sda_s;
  wire               start_det;
  wire               stop_det;
  wire               wr_edge;
  wire               ptr_edge;
  wire               rd_edge;
  wire               fetch_req;
  wire               link_arst;

  chgi2c_mon_if mon ();

  // ---------------------------------------------------------------
  // Link domain declarations
  // ---------------------------------------------------------------
  chgi2c_state_type  state_r;
  chgi2c_state_type  state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [7:0]        rx_r;
  logic [7:0]        tx_r;
  logic [7:0]        tx_nxt;
  logic [7:0]        ptr_r;
  logic [7:0]        ptr_nxt;
  logic [7:0]        wdat_r;
  logic [7:0]        wdat_nxt;
  logic              wr_tgl_r;
  logic              wr_tgl_nxt;
  logic              ptr_tgl_r;
  logic              ptr_tgl_nxt;
  logic              rd_tgl_r;
  logic              rd_tgl_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic              armed_r;
  logic              sda_pos_r;
  logic              mst_nack_r;

  wire               rep_start;
  wire               frame_open;
  wire               byte_end;
  wire               ack_end;
  wire               addr_hit;
  wire               dir_read;
  wire [7:0]         rx_nxt;

  // ---------------------------------------------------------------
  // Pin and toggle synchronisers
  // ---------------------------------------------------------------
  // Idle-high reset keeps a fake START away after reset
  chgi2c_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({scl_clk_i, sda_i}),
    .sync_o    (pin_s)
  );

  chgi2c_sync #(
    .W       (3),
    .RST_VAL (3'h0)
  ) u_tgl_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({rd_tgl_r, ptr_tgl_r, wr_tgl_r}),
    .sync_o    (tgl_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // ---------------------------------------------------------------
  // START / STOP seen at system rate
  // ---------------------------------------------------------------
  assign start_det = scl_s & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & ~sda_d_r & sda_s;

  assign mon.start   = start_det;
  assign mon.stop    = stop_det;
  assign mon.sda_low = ~sda_s;

  chgi2c_stuck_timer #(
    .LIMIT (STUCK_CYCLES)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .mon       (mon)
  );

  // Link engine is held in reset from STOP or timeout until a START.
  // START wins: the timer restarts on it in the same cycle.
  assign link_rst_nxt = start_det ? 1'b0 :
                        ((stop_det | mon.timeout) ? 1'b1 : link_rst_r);

  // Release happens with the clock line high, long before its fall,
  // so the link flops see no edge near the release.
  assign link_arst = rst_i | link_rst_r;

  // ---------------------------------------------------------------
  // Toggle handshakes from the link domain
  // ---------------------------------------------------------------
  assign wr_edge   = tgl_s[0] ^ tgl_d_r[0];
  assign ptr_edge  = tgl_s[1] ^ tgl_d_r[1];
  assign rd_edge   = tgl_s[2] ^ tgl_d_r[2];
  assign fetch_req = start_det | ptr_edge | rd_edge;

  // Two-stage delay lets the core apply a clear-on-read before refetch
  assign rd_byte_nxt = fetch_q_r[1] ? (reg_valid_i ? reg_rdata_i : UNMAPPED_RD) : rd_byte_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_d_r    <= 1'b1;
      link_rst_r <= 1'b1;
      tgl_d_r    <= 3'h0;
      timeout_r  <= 1'b0;
    end else begin
      sda_d_r    <= sda_s;
      link_rst_r <= link_rst_nxt;
      tgl_d_r    <= tgl_s;
      timeout_r  <= mon.timeout;
    end
  end

  // Link-domain words are stable for a whole byte when the toggle lands
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_addr_r  <= BYTE_RST;
      reg_wdata_r <= BYTE_RST;
      reg_wr_r    <= 1'b0;
      reg_rd_r    <= 1'b0;
    end else begin
      reg_addr_r  <= ptr_edge ? ptr_r : reg_addr_r;
      reg_wdata_r <= wr_edge ? wdat_r : reg_wdata_r;
      reg_wr_r    <= wr_edge;
      reg_rd_r    <= rd_edge;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_q_r <= 2'h0;
      rd_byte_r <= UNMAPPED_RD;
    end else begin
      fetch_q_r <= {fetch_q_r[0], fetch_req};
      rd_byte_r <= rd_byte_nxt;
    end
  end

  assign reg_addr_o  = reg_addr_r;
  assign reg_wdata_o = reg_wdata_r;
  assign reg_wr_o    = reg_wr_r;
  assign reg_rd_o    = reg_rd_r;
  assign busy_o      = mon.running;
  assign timeout_o   = timeout_r;

  // ---------------------------------------------------------------
  // Link domain: bit engine on the bus clock
  // ---------------------------------------------------------------
  // No rate-dependent timing: every action follows a clock edge
  assign rx_nxt = {rx_r[6:0], sda_i};

  always_ff @(posedge scl_clk_i or posedge link_arst) begin
    if (link_arst) begin
      rx_r       <= BYTE_RST;
      sda_pos_r  <= 1'b0;
      mst_nack_r <= 1'b1;
    end else begin
      sda_pos_r  <= sda_i;
      rx_r       <= (cnt_r < BIT_ACK) ? rx_nxt : rx_r;
      mst_nack_r <= (cnt_r == BIT_ACK) ? sda_i : mst_nack_r;
    end
  end

  // High at rising edge, low at falling edge: START inside the high phase
  assign rep_start  = armed_r & sda_pos_r & ~sda_i;
  // First fall after release is the fall of the START itself
  assign frame_open = ~armed_r | rep_start;
  assign byte_end   = (cnt_r == BIT_LAST);
  assign ack_end    = (cnt_r == BIT_ACK);
  assign addr_hit   = (rx_r[7:1] == DEV_ADDR);
  assign dir_read   = rx_r[DIR_BIT];

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = ack_end ? CNT_RST : cnt_r + 4'h1;
    oe_nxt      = 1'b0;
    tx_nxt      = {tx_r[6:0], 1'b1};
    ptr_nxt     = ptr_r;
    wdat_nxt    = wdat_r;
    wr_tgl_nxt  = wr_tgl_r;
    ptr_tgl_nxt = ptr_tgl_r;
    rd_tgl_nxt  = rd_tgl_r;
    if (frame_open) begin
      state_nxt = ST_ADDR;
      cnt_nxt   = CNT_RST;
      tx_nxt    = tx_r;
    end else begin
      case (state_r)
        ST_ADDR: begin
          if (byte_end) begin
            if (addr_hit) begin
              oe_nxt    = 1'b1;
              state_nxt = dir_read ? ST_RD : ST_PTR;
            end else begin
              state_nxt = ST_IGNORE;
            end
          end
        end
        ST_PTR: begin
          if (byte_end) begin
            oe_nxt      = 1'b1;
            ptr_nxt     = rx_r;
            ptr_tgl_nxt = ~ptr_tgl_r;
            state_nxt   = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_end) begin
            oe_nxt     = 1'b1;
            wdat_nxt   = rx_r;
            wr_tgl_nxt = ~wr_tgl_r;
          end
        end
        ST_RD: begin
          if (ack_end) begin
            if (mst_nack_r) begin
              state_nxt = ST_IGNORE;
            end else begin
              tx_nxt     = rd_byte_r;
              oe_nxt     = ~rd_byte_r[7];
              rd_tgl_nxt = ~rd_tgl_r;
            end
          end else if (!byte_end) begin
            oe_nxt = ~tx_nxt[7];
          end
        end
        ST_IGNORE: begin
          state_nxt = ST_IGNORE;
        end
        default: begin
          state_nxt = ST_IGNORE;
        end
      endcase
    end
  end

  // Data changes only after the clock falls, so the master sees it
  // stable through the whole high phase.
  always_ff @(negedge scl_clk_i or posedge link_arst) begin
    if (link_arst) begin
      state_r <= ST_ADDR;
      cnt_r   <= CNT_RST;
      oe_r    <= 1'b0;
      tx_r    <= UNMAPPED_RD;
      armed_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      oe_r    <= oe_nxt;
      tx_r    <= tx_nxt;
      armed_r <= 1'b1;
    end
  end

  // Handshake words survive link resets so the system side never
  // sees a spurious toggle.
  always_ff @(negedge scl_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_r     <= BYTE_RST;
      wdat_r    <= BYTE_RST;
      wr_tgl_r  <= 1'b0;
      ptr_tgl_r <= 1'b0;
      rd_tgl_r  <= 1'b0;
    end else begin
      ptr_r     <= ptr_nxt;
      wdat_r    <= wdat_nxt;
      wr_tgl_r  <= wr_tgl_nxt;
      ptr_tgl_r <= ptr_tgl_nxt;
      rd_tgl_r  <= rd_tgl_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_r;

endmodule // chgi2c_top

/* chgi2c_assertions.sv */
`timescale 1ns/1ps
module chgi2c_assertions #(
  parameter int unsigned STUCK_CYCLES = chgi2c_pkg::STUCK_BUS_TIMEOUT_CYC
) (
  input wire logic                          sys_clk_i,
  input wire logic                          rst_i,
  input wire logic                          scl_clk_i,
  input wire logic                          sda_i,
  input wire logic                          sda_o,
  input wire logic                          sda_oe_o,
  input wire logic [chgi2c_pkg::BYTE_W-1:0] reg_wdata_o,
  input wire logic                          reg_wr_o,
  input wire logic                          reg_rd_o,
  input wire logic                          busy_o,
  input wire logic                          timeout_o
);
  import chgi2c_pkg::*;
  logic [31:0] low_r;
  logic [31:0] run_r;
  // Last run kept, since the synchroniser lets the timer fire after sda rose
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_r <= '0;
      run_r <= '0;
    end else if (sda_i) begin
      low_r <= '0;
      run_r <= (low_r != 0) ? low_r : run_r;
    end else begin
      low_r <= low_r + 1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start; $fell(sda_i) && scl_clk_i && $past(scl_clk_i); endsequence
  sequence s_stop; $rose(sda_i) && scl_clk_i && $past(scl_clk_i); endsequence
  // Released link: no pull once the frame has ended for a full cycle
  property p_open_drain;
    (!busy_o && !$past(busy_o)) |-> (!sda_oe_o && (sda_o == 1'b0));
  endproperty
  property p_oe_edge; $changed(sda_oe_o) |-> !scl_clk_i; endproperty
  property p_ack_stands; $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
  property p_oe_in_frame; $rose(sda_oe_o) |-> busy_o; endproperty
  property p_start_busy; s_start |-> ##[1:6] busy_o; endproperty
  property p_stop_idle; s_stop |-> ##[1:6] !busy_o; endproperty
  property p_to_cause;
    timeout_o |-> (low_r + 8 >= STUCK_CYCLES) || (run_r + 8 >= STUCK_CYCLES);
  endproperty
  property p_to_end; timeout_o |=> !timeout_o && !busy_o; endproperty
  property p_pulse; (reg_wr_o || reg_rd_o) |=> !(reg_wr_o || reg_rd_o); endproperty
  property p_wdata_hold; $changed(reg_wdata_o) |-> reg_wr_o; endproperty
  a_open_drain: assert property (p_open_drain) else $error("drive while released");
  a_oe_edge: assert property (p_oe_edge) else $error("oe moved in clock high");
  a_ack_stands: assert property (p_ack_stands) else $error("ack too short");
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("drive outside frame");
  a_start_busy: assert property (p_start_busy) else $error("start missed");
  a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
  a_to_cause: assert property (p_to_cause) else $error("early timeout");
  a_to_end: assert property (p_to_end) else $error("timeout not ending frame");
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  a_wdata_hold: assert property (p_wdata_hold) else $error("wdata moved");
  c_wr: cover property (reg_wr_o);
  c_rd: cover property (reg_rd_o);
  c_to: cover property (timeout_o);
endmodule // chgi2c_assertions

bind chgi2c_top chgi2c_assertions #(.STUCK_CYCLES(STUCK_CYCLES)) chgi2c_assertions_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
  .reg_rd_o(reg_rd_o), .busy_o(busy_o), .timeout_o(timeout_o));

/* chgi2c_host_model.sv */
`timescale 1ns/1ps
module chgi2c_host_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start_x();
    // Data moves only well after the clock fall, never at it
    #40 sda_o = 1'b1;
    #40.7 scl_o = 1'b1;
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask
  task automatic bit_x(input logic b, output logic s);
    #40 sda_o = b;
    #40 scl_o = 1'b1;
    #40 s = sda_i;
    #40 scl_o = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
  task automatic hold_x(input int ns);
    #40 sda_o = 1'b0;
    #(ns);
  endtask
  task automatic stop_x();
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b1;
    #80 sda_o = 1'b1;
    #80;
  endtask
endmodule // chgi2c_host_model

/* charger_i2c_slave_port_test.sv */
`timescale 1ns/1ps
module charger_i2c_slave_port_test;
  import chgi2c_pkg::*;
  localparam int unsigned STUCK = 1000;
  logic       sys_clk = 1'b0;
  // Raised after time zero so every async reset process sees an edge
  logic       rst = 1'b0;
  logic       to_seen = 1'b0;
  logic [7:0] regs [8];
  logic       scl, host_sda, sda_o, sda_oe, reg_wr, reg_rd, busy, tmo;
  logic [7:0] reg_addr, reg_wdata;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         rd_cnt = 0;
  always #2 sys_clk = ~sys_clk;
  // Pull-up: the wire is low while either side pulls
  wire logic       sda_w = host_sda & ~sda_oe;
  wire logic       reg_valid = reg_addr < 8'h08;
  wire logic [7:0] reg_rdata = regs[reg_addr[2:0]];
  always @(posedge sys_clk) begin
    if (reg_wr === 1'b1) regs[reg_addr[2:0]] <= reg_wdata;
    if (tmo === 1'b1) to_seen <= 1'b1;
    if (reg_rd === 1'b1) rd_cnt <= rd_cnt + 1;
  end
  chgi2c_top #(.STUCK_CYCLES(STUCK)) chgi2c_top_i (
    .sys_clk_i(sys_clk), .rst_i(rst), .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .reg_valid_i(reg_valid), .busy_o(busy),
    .timeout_o(tmo));
  chgi2c_host_model chgi2c_host_model_i (.sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Mismatches %0d in %0d checks", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic st();
    chgi2c_host_model_i.start_x();
  endtask
  task automatic sp();
    chgi2c_host_model_i.stop_x();
  endtask
  task automatic wb(input logic [7:0] d, input logic exp_k);
    logic [7:0] q;
    logic       k;
    chgi2c_host_model_i.byte_x(d, 1'b1, q, k);
    chk({7'h00, k}, {7'h00, exp_k});
  endtask
  task automatic rb(input logic a, input logic [7:0] exp);
    logic [7:0] q;
    logic       k;
    chgi2c_host_model_i.byte_x(8'hFF, a, q, k);
    chk(q, exp);
  endtask
  task automatic set_ptr(input logic [7:0] p);
    st();
    wb(8'hD4, 1'b0);
    wb(p, 1'b0);
  endtask
  task automatic t_reset();
    chk({6'h00, busy, sda_oe}, 8'h00);
    chk(reg_addr, 8'h00);
  endtask
  task automatic t_write(input logic [7:0] p, input logic [7:0] nxt_exp);
    set_ptr(p);
    chk(reg_addr, p);
    wb(8'hA5, 1'b0);
    wb(8'h5A, 1'b0);
    sp();
    repeat (8) @(posedge sys_clk);
    chk(regs[p[2:0]], 8'h5A);
    chk(regs[p[2:0] + 3'h1], nxt_exp);
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic t_read();
    int rd0;
    rd0 = rd_cnt;
    set_ptr(8'h03);
    st();
    wb(8'hD5, 1'b0);
    rb(1'b0, 8'h5A);
    rb(1'b1, 8'h5A);
    sp();
    // Two loads: after the address ack and after the master ack
    chk(8'(rd_cnt - rd0), 8'h02);
  endtask
  task automatic t_unmapped();
    set_ptr(8'h40);
    st();
    wb(8'hD5, 1'b0);
    rb(1'b1, 8'hFF);
    sp();
  endtask
  task automatic t_wrong();
    st();
    wb(8'hD6, 1'b1);
    wb(8'h00, 1'b1);
    sp();
    wb(8'hD4, 1'b1);
    sp();
  endtask
  task automatic t_timeout();
    st();
    wb(8'hD4, 1'b0);
    chgi2c_host_model_i.hold_x(STUCK * 4 + 400);
    chk({7'h00, to_seen}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    wb(8'hD4, 1'b1);
    sp();
  endtask
  initial begin
    for (int i = 0; i < 8; i++) regs[i] = 8'(8'h11 * i);
    #1 rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_reset();
    // Output rail is taken as up once these cycles have passed
    repeat (4) @(posedge sys_clk);
    #1 t_write(8'h03, 8'h44);
    t_read();
    t_unmapped();
    t_wrong();
    t_timeout();
    // Different register, so a lost write after the timeout shows
    t_write(8'h05, 8'h66);
    end_sim();
  end
  // Whole run is near 40 us of bus time
  initial begin
    #200_000;
    bad_count++;
    end_sim();
  end
endmodule // charger_i2c_slave_port_test
